/* File: inc/framer_params.svh */
// Constants for the serial packet forwarding framer.
`ifndef FRAMER_PARAMS_SVH
`define FRAMER_PARAMS_SVH

// ==========================================================
// Widths
// ==========================================================
`define FR_CNT_W 11
`define FR_MS_W 16
`define FR_TICK_W 16
`define FR_CHAR_W 8

// ==========================================================
// Sizes and counts
// ==========================================================
`define FR_MAX_BYTES 11'h0400
`define FR_THRU_IDLE_MS 16'h0005
`define FR_MS_MAX 16'hffff
`define FR_TAIL_NONE 2'h0
`define FR_TAIL_ONE 2'h1
`define FR_TAIL_TWO 2'h2
`define FR_LANES_NONE 2'h0
`define FR_LANE_ONE 2'h1
`define FR_LANES_TWO 2'h2
`define FR_SIZE_OFF 11'h0000
`define FR_MS_OFF 16'h0000
`define FR_DELAY_DEFAULT 16'h00fa

// ==========================================================
// Timing
// ==========================================================
`define FR_MS_NS 1000000
`define FR_CLK_NS 25
`define FR_MS_CYCLES (`FR_MS_NS / `FR_CLK_NS)

`endif

/* File: inc/framer_pkg.sv */
// Types shared by the serial packet forwarding framer.
`include "framer_params.svh"

package framer_pkg;
   typedef enum logic [1:0] {MODE_LATENCY, MODE_THROUGHPUT, MODE_FRAGMENT, MODE_CUSTOM} fwd_mode_e;
   typedef enum logic [1:0] {RULE_STRIP, RULE_INCLUDE, RULE_PLUS1, RULE_PLUS2} rule_e;
   typedef enum logic [1:0] {FR_HUNT, FR_START_B, FR_IN} frame_e;

   typedef struct packed {
      fwd_mode_e mode;
      logic [`FR_MS_W-1:0] msg_delay_ms;
      logic use_frame;
      logic [`FR_CNT_W-1:0] pkt_size;
      logic [`FR_MS_W-1:0] idle_ms;
      logic [`FR_MS_W-1:0] force_ms;
      logic ready_a_en;
      logic [`FR_CHAR_W-1:0] packet_ready_char_a;
      logic ready_b_en;
      logic [`FR_CHAR_W-1:0] packet_ready_char_b;
      logic start_b_en;
      logic [`FR_CHAR_W-1:0] frame_start_char_a;
      logic [`FR_CHAR_W-1:0] frame_start_char_b;
      logic send_start;
      logic [`FR_CHAR_W-1:0] frame_end_char_a;
      logic end_b_en;
      logic [`FR_CHAR_W-1:0] frame_end_char_b;
      rule_e rule;
   } cfg_s;

   typedef struct packed {
      logic [1:0] cnt;
      logic [`FR_CHAR_W-1:0] b0;
      logic [`FR_CHAR_W-1:0] b1;
      logic last;
   } tx_s;

   typedef struct packed {
      tx_s tx;
      frame_e fstate;
      logic pend;
      logic [1:0] tail;
      logic open;
      logic [`FR_CNT_W-1:0] nbytes;
      logic [`FR_MS_W-1:0] idle;
      logic [`FR_MS_W-1:0] force_t;
      logic [`FR_TICK_W-1:0] tick;
   } state_s;
endpackage : framer_pkg

/* File: logic/serial_packet_forwarding_framer.sv */
// Serial packet forwarding framer: groups received serial bytes into network packets.
`timescale 1ns/1ps
`include "framer_params.svh"

module serial_packet_forwarding_framer #(
   parameter int MS_CYCLES = `FR_MS_CYCLES
) (
   // Clock, reset and enable
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ce,
   // Configuration
   input wire framer_pkg::cfg_s cfg,
   // Serial receive side
   input wire logic rx_valid,
   input wire logic [`FR_CHAR_W-1:0] rx_data,
   // Network transmit side
   output framer_pkg::tx_s tx,
   output logic pending
);

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic framer_pkg::tx_s push_byte(input framer_pkg::tx_s t, input logic [`FR_CHAR_W-1:0] b);
      framer_pkg::tx_s r;
      r = t;
      if (t.cnt == `FR_LANES_NONE) begin
         r.b0 = b;
      end else begin
         r.b1 = b;
      end
      r.cnt = 2'(t.cnt + `FR_LANE_ONE);
      return r;
   endfunction : push_byte

   function automatic logic [`FR_MS_W-1:0] sat_inc(input logic [`FR_MS_W-1:0] v);
      return (v == `FR_MS_MAX) ? v : `FR_MS_W'(v + 1'b1);
   endfunction : sat_inc

   // ==========================================================
   // State
   // ==========================================================
   framer_pkg::state_s s_r;
   framer_pkg::state_s s_nxt;
   logic tick_hit;
   logic endp;
   logic eof_hit;
   logic mark;
   logic pkt_mode;
   logic [`FR_CHAR_W-1:0] ca;
   logic [`FR_CHAR_W-1:0] cb;
   logic ea;
   logic eb;

   assign tx = s_r.tx;
   assign pending = s_r.open;

   // The mode is a single encoded field, so no two modes can ever be active together.
   assign pkt_mode = (cfg.mode == framer_pkg::MODE_CUSTOM) && !cfg.use_frame;
   assign ca = cfg.use_frame ? cfg.frame_end_char_a : cfg.packet_ready_char_a;
   assign cb = cfg.use_frame ? cfg.frame_end_char_b : cfg.packet_ready_char_b;
   assign ea = cfg.use_frame | cfg.ready_a_en;
   assign eb = ea & (cfg.use_frame ? cfg.end_b_en : cfg.ready_b_en);

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      s_nxt = s_r;
      s_nxt.tx = '0;
      endp = 1'b0;
      eof_hit = 1'b0;
      mark = 1'b0;
      tick_hit = (s_r.tick == `FR_TICK_W'(MS_CYCLES - 1));
      s_nxt.tick = tick_hit ? '0 : `FR_TICK_W'(s_r.tick + 1'b1);
      if (rx_valid) begin
         s_nxt.idle = '0;
         case (cfg.mode)
            framer_pkg::MODE_LATENCY: begin
               s_nxt.tx = push_byte(s_nxt.tx, rx_data);
               endp = 1'b1;
            end
            framer_pkg::MODE_CUSTOM: begin
               if (s_r.tail != `FR_TAIL_NONE) begin
                  s_nxt.tx = push_byte(s_nxt.tx, rx_data);
                  s_nxt.tail = 2'(s_r.tail - 1'b1);
                  if (s_nxt.tail == `FR_TAIL_NONE) begin
                     endp = 1'b1;
                     eof_hit = 1'b1;
                  end
               end else if (cfg.use_frame && s_r.fstate == framer_pkg::FR_HUNT) begin
                  if (rx_data == cfg.frame_start_char_a) begin
                     if (cfg.start_b_en) begin
                        s_nxt.fstate = framer_pkg::FR_START_B;
                     end else begin
                        s_nxt.fstate = framer_pkg::FR_IN;
                        if (cfg.send_start) begin
                           s_nxt.tx = push_byte(s_nxt.tx, rx_data);
                        end
                     end
                  end
               end else if (cfg.use_frame && s_r.fstate == framer_pkg::FR_START_B) begin
                  if (rx_data == cfg.frame_start_char_b) begin
                     s_nxt.fstate = framer_pkg::FR_IN;
                     if (cfg.send_start) begin
                        s_nxt.tx = push_byte(s_nxt.tx, cfg.frame_start_char_a);
                        s_nxt.tx = push_byte(s_nxt.tx, rx_data);
                     end
                  end else if (rx_data != cfg.frame_start_char_a) begin
                     s_nxt.fstate = framer_pkg::FR_HUNT;
                  end
               end else if (s_r.pend) begin
                  if (rx_data == cb) begin
                     mark = 1'b1;
                     if (cfg.rule != framer_pkg::RULE_STRIP) begin
                        s_nxt.tx = push_byte(s_nxt.tx, ca);
                        s_nxt.tx = push_byte(s_nxt.tx, rx_data);
                     end
                  end else begin
                     // A broken pair is ordinary data; the new byte may itself restart the pair.
                     s_nxt.tx = push_byte(s_nxt.tx, ca);
                     s_nxt.pend = (rx_data == ca);
                     if (rx_data != ca) begin
                        s_nxt.tx = push_byte(s_nxt.tx, rx_data);
                     end
                  end
               end else if (ea && rx_data == ca) begin
                  if (eb) begin
                     s_nxt.pend = 1'b1;
                  end else begin
                     mark = 1'b1;
                     if (cfg.rule != framer_pkg::RULE_STRIP) begin
                        s_nxt.tx = push_byte(s_nxt.tx, rx_data);
                     end
                  end
               end else begin
                  s_nxt.tx = push_byte(s_nxt.tx, rx_data);
               end
               if (mark) begin
                  s_nxt.pend = 1'b0;
                  case (cfg.rule)
                     framer_pkg::RULE_PLUS1: s_nxt.tail = `FR_TAIL_ONE;
                     framer_pkg::RULE_PLUS2: s_nxt.tail = `FR_TAIL_TWO;
                     default: begin
                        endp = 1'b1;
                        eof_hit = 1'b1;
                     end
                  endcase
               end
            end
            default: begin
               s_nxt.tx = push_byte(s_nxt.tx, rx_data);
            end
         endcase
      end
      s_nxt.nbytes = `FR_CNT_W'(s_r.nbytes + `FR_CNT_W'(s_nxt.tx.cnt));
      if (s_nxt.tx.cnt != `FR_LANES_NONE || s_nxt.pend || s_nxt.tail != `FR_TAIL_NONE) begin
         s_nxt.open = 1'b1;
      end
      if (rx_valid) begin
         if (cfg.mode == framer_pkg::MODE_THROUGHPUT && s_nxt.nbytes >= `FR_MAX_BYTES) begin
            endp = 1'b1;
         end
         if (cfg.mode == framer_pkg::MODE_FRAGMENT && cfg.msg_delay_ms == `FR_MS_OFF) begin
            endp = 1'b1;
         end
         if (cfg.mode == framer_pkg::MODE_CUSTOM && cfg.use_frame && s_nxt.nbytes >= `FR_MAX_BYTES) begin
            endp = 1'b1;
         end
         if (pkt_mode && cfg.pkt_size != `FR_SIZE_OFF && s_nxt.nbytes >= cfg.pkt_size) begin
            endp = 1'b1;
         end
      end
      if (tick_hit && s_r.open) begin
         s_nxt.force_t = sat_inc(s_r.force_t);
         if (!rx_valid) begin
            s_nxt.idle = sat_inc(s_r.idle);
         end
         if ((cfg.mode == framer_pkg::MODE_FRAGMENT && !rx_valid && s_nxt.idle >= cfg.msg_delay_ms)
               || (cfg.mode == framer_pkg::MODE_THROUGHPUT && !rx_valid && s_nxt.idle >= `FR_THRU_IDLE_MS)
               || (pkt_mode && !rx_valid && cfg.idle_ms != `FR_MS_OFF && s_nxt.idle >= cfg.idle_ms)
               || (pkt_mode && cfg.force_ms != `FR_MS_OFF && s_nxt.force_t >= cfg.force_ms)) begin
            endp = 1'b1;
            if (s_r.pend && !rx_valid) begin
               s_nxt.tx = push_byte(s_nxt.tx, ca);
               s_nxt.pend = 1'b0;
            end
         end
      end
      if (endp && (s_r.open || s_nxt.tx.cnt != `FR_LANES_NONE)) begin
         // A packet closes here on a trigger, a size limit or a timer; latency mode sends every byte in a packet of its own.
         s_nxt.tx.last = 1'b1;
         s_nxt.open = s_nxt.pend || (s_nxt.tail != `FR_TAIL_NONE);
         s_nxt.nbytes = '0;
         s_nxt.idle = '0;
         s_nxt.force_t = '0;
      end
      if (eof_hit && cfg.use_frame) begin
         s_nxt.fstate = framer_pkg::FR_HUNT;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   property p_latency_each;
      @(posedge mclk) disable iff (!arst_n)
         ce && rx_valid && cfg.mode == framer_pkg::MODE_LATENCY |=> tx.cnt == `FR_LANE_ONE && tx.last
            && tx.b0 == $past(rx_data);
   endproperty
   a_latency_each: assert property (p_latency_each) else $error("latency byte not sent alone");

   property p_hunt_drop;
      @(posedge mclk) disable iff (!arst_n)
         ce && rx_valid && cfg.mode == framer_pkg::MODE_CUSTOM && cfg.use_frame && s_r.fstate == framer_pkg::FR_HUNT
            && rx_data != cfg.frame_start_char_a |=> tx.cnt == `FR_LANES_NONE && s_r.fstate == framer_pkg::FR_HUNT;
   endproperty
   a_hunt_drop: assert property (p_hunt_drop) else $error("byte before frame start not dropped");

   property p_start_strip;
      @(posedge mclk) disable iff (!arst_n)
         ce && rx_valid && cfg.mode == framer_pkg::MODE_CUSTOM && cfg.use_frame && s_r.fstate == framer_pkg::FR_HUNT
            && rx_data == cfg.frame_start_char_a && !cfg.start_b_en
            |=> s_r.fstate == framer_pkg::FR_IN && tx.cnt == ($past(cfg.send_start) ? `FR_LANE_ONE : `FR_LANES_NONE);
   endproperty
   a_start_strip: assert property (p_start_strip) else $error("start character handling wrong");

   property p_end_include;
      @(posedge mclk) disable iff (!arst_n)
         ce && rx_valid && cfg.mode == framer_pkg::MODE_CUSTOM && s_r.tail == `FR_TAIL_NONE && !s_r.pend
            && (!cfg.use_frame || s_r.fstate == framer_pkg::FR_IN) && ea && !eb && rx_data == ca
            && cfg.rule == framer_pkg::RULE_INCLUDE |=> tx.last && tx.cnt == `FR_LANE_ONE && tx.b0 == $past(ca);
   endproperty
   a_end_include: assert property (p_end_include) else $error("end character did not close packet");

   property p_end_strip;
      @(posedge mclk) disable iff (!arst_n)
         ce && rx_valid && cfg.mode == framer_pkg::MODE_CUSTOM && s_r.tail == `FR_TAIL_NONE && !s_r.pend
            && (!cfg.use_frame || s_r.fstate == framer_pkg::FR_IN) && ea && !eb && rx_data == ca
            && cfg.rule == framer_pkg::RULE_STRIP && s_r.open |=> tx.last && tx.cnt == `FR_LANES_NONE;
   endproperty
   a_end_strip: assert property (p_end_strip) else $error("stripped trigger was sent");

   property p_pair_break;
      @(posedge mclk) disable iff (!arst_n)
         ce && rx_valid && pkt_mode && s_r.pend && s_r.tail == `FR_TAIL_NONE && rx_data != cb && rx_data != ca
            && cfg.pkt_size == `FR_SIZE_OFF && cfg.force_ms == `FR_MS_OFF
            |=> tx.cnt == `FR_LANES_TWO && !tx.last && !s_r.pend;
   endproperty
   a_pair_break: assert property (p_pair_break) else $error("broken trigger pair mishandled");

   property p_trigger_single;
      @(posedge mclk) disable iff (!arst_n)
         ce && rx_valid && pkt_mode && !s_r.pend && s_r.tail == `FR_TAIL_NONE && cfg.ready_a_en
            && cfg.ready_b_en && rx_data == cfg.packet_ready_char_a && cfg.force_ms == `FR_MS_OFF
            |=> s_r.pend && !tx.last;
   endproperty
   a_trigger_single: assert property (p_trigger_single) else $error("first trigger alone closed packet");

   property p_size_release;
      @(posedge mclk) disable iff (!arst_n)
         ce && rx_valid && pkt_mode && cfg.pkt_size != `FR_SIZE_OFF && !s_r.pend && s_r.tail == `FR_TAIL_NONE
            && !cfg.ready_a_en && `FR_CNT_W'(s_r.nbytes + 1'b1) == cfg.pkt_size
            |=> tx.last && s_r.nbytes == '0;
   endproperty
   a_size_release: assert property (p_size_release) else $error("byte count did not release");

   property p_frame_full;
      @(posedge mclk) disable iff (!arst_n)
         ce && rx_valid && cfg.mode == framer_pkg::MODE_CUSTOM && cfg.use_frame && s_r.fstate == framer_pkg::FR_IN
            && !s_r.pend && s_r.tail == `FR_TAIL_NONE && rx_data != ca
            && s_r.nbytes == `FR_CNT_W'(`FR_MAX_BYTES - 1'b1) |=> tx.last && s_r.fstate == framer_pkg::FR_IN;
   endproperty
   a_frame_full: assert property (p_frame_full) else $error("full frame buffer not sent");

   property p_frag_gap;
      @(posedge mclk) disable iff (!arst_n)
         ce && tick_hit && !rx_valid && s_r.open && !s_r.pend && cfg.mode == framer_pkg::MODE_FRAGMENT
            && cfg.msg_delay_ms != `FR_MS_OFF && sat_inc(s_r.idle) == cfg.msg_delay_ms |=> tx.last && !pending;
   endproperty
   a_frag_gap: assert property (p_frag_gap) else $error("message gap did not close packet");

endmodule : serial_packet_forwarding_framer

/* File: tb/serial_device_model.sv */
// Serial device model that presents received bytes to the framer.
`timescale 1ns/1ps
module serial_device_model (
   // Byte strobe toward the framer
   output logic rx_valid,
   output logic [7:0] rx_data
);
   logic [7:0] last_b;
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      last_b = 8'h00;
   end
   // Called just after a falling edge, so the byte is sampled cleanly at the next rising edge.
   task automatic put(input logic [7:0] b);
      rx_valid = 1'b1;
      rx_data = b;
      last_b = b;
   endtask : put
   // A line at rest shows the inverse of the last byte, so stale data can never pass for a repeat.
   task automatic idle();
      rx_valid = 1'b0;
      rx_data = ~last_b;
   endtask : idle
endmodule : serial_device_model

/* File: tb/serial_packet_forwarding_framer_tb_top.sv */
// Self-checking testbench for the serial packet forwarding framer.
`timescale 1ns/1ps
module serial_packet_forwarding_framer_tb_top;
   // ==========================================================
   // Signals and instances
   // ==========================================================
   typedef struct packed {logic [2:0] grp; logic [7:0] d; logic [1:0] cnt; logic [7:0] b0; logic [7:0] b1;
      logic last; logic [1:0] pend;} row_s;
   logic mclk;
   logic arst_n;
   logic ce;
   framer_pkg::cfg_s cfg;
   logic rx_valid;
   logic [7:0] rx_data;
   framer_pkg::tx_s tx;
   logic pending;
   int miscompares = 0;
   int checked = 0;
   int cyc = 0;
   int n;
   logic [7:0] seq [3] = '{8'h0d, 8'h01, 8'h02};
   row_s rows [27] = '{
      '{3'h0, 8'h5a, 2'h1, 8'h5a, 8'h00, 1'b1, 2'h0}, '{3'h0, 8'ha5, 2'h1, 8'ha5, 8'h00, 1'b1, 2'h0},
      '{3'h1, 8'h41, 2'h1, 8'h41, 8'h00, 1'b0, 2'h1}, '{3'h1, 8'h0d, 2'h0, 8'h00, 8'h00, 1'b0, 2'h1},
      '{3'h1, 8'h0a, 2'h2, 8'h0d, 8'h0a, 1'b1, 2'h0}, '{3'h1, 8'h0d, 2'h0, 8'h00, 8'h00, 1'b0, 2'h1},
      '{3'h1, 8'h33, 2'h2, 8'h0d, 8'h33, 1'b0, 2'h1}, '{3'h1, 8'h0d, 2'h0, 8'h00, 8'h00, 1'b0, 2'h1},
      '{3'h1, 8'h0a, 2'h2, 8'h0d, 8'h0a, 1'b1, 2'h0}, '{3'h2, 8'h11, 2'h1, 8'h11, 8'h00, 1'b0, 2'h1},
      '{3'h2, 8'h12, 2'h1, 8'h12, 8'h00, 1'b0, 2'h1}, '{3'h2, 8'h13, 2'h1, 8'h13, 8'h00, 1'b1, 2'h0},
      '{3'h2, 8'h14, 2'h1, 8'h14, 8'h00, 1'b0, 2'h1}, '{3'h3, 8'h77, 2'h0, 8'h00, 8'h00, 1'b0, 2'h0},
      '{3'h3, 8'h02, 2'h0, 8'h00, 8'h00, 1'b0, 2'h2}, '{3'h3, 8'h44, 2'h1, 8'h44, 8'h00, 1'b0, 2'h1},
      '{3'h3, 8'h03, 2'h1, 8'h03, 8'h00, 1'b1, 2'h0}, '{3'h3, 8'h55, 2'h0, 8'h00, 8'h00, 1'b0, 2'h0},
      '{3'h4, 8'h02, 2'h1, 8'h02, 8'h00, 1'b0, 2'h2}, '{3'h4, 8'h03, 2'h1, 8'h03, 8'h00, 1'b1, 2'h0},
      '{3'h5, 8'h02, 2'h0, 8'h00, 8'h00, 1'b0, 2'h2}, '{3'h5, 8'h99, 2'h0, 8'h00, 8'h00, 1'b0, 2'h2},
      '{3'h5, 8'h44, 2'h0, 8'h00, 8'h00, 1'b0, 2'h2}, '{3'h5, 8'h02, 2'h0, 8'h00, 8'h00, 1'b0, 2'h2},
      '{3'h5, 8'h2b, 2'h0, 8'h00, 8'h00, 1'b0, 2'h2}, '{3'h5, 8'h44, 2'h1, 8'h44, 8'h00, 1'b0, 2'h1},
      '{3'h5, 8'h03, 2'h1, 8'h03, 8'h00, 1'b1, 2'h0}};

   serial_device_model ser (.rx_valid(rx_valid), .rx_data(rx_data));
   // A short millisecond keeps the timer tests brief; all timer bounds below assume ten cycles.
   serial_packet_forwarding_framer #(.MS_CYCLES(10)) dut (.mclk(mclk), .arst_n(arst_n), .ce(ce), .cfg(cfg),
      .rx_valid(rx_valid), .rx_data(rx_data), .tx(tx), .pending(pending));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         wrap_up();
      end
   end

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic framer_pkg::cfg_s base_cfg(input logic [2:0] g);
      framer_pkg::cfg_s c;
      c = '0;
      c.mode = (g == 3'h0) ? framer_pkg::MODE_LATENCY : framer_pkg::MODE_CUSTOM;
      c.msg_delay_ms = 16'h00fa;
      c.rule = framer_pkg::RULE_INCLUDE;
      c.ready_a_en = (g == 3'h1);
      c.packet_ready_char_a = 8'h0d;
      c.ready_b_en = (g == 3'h1);
      c.packet_ready_char_b = 8'h0a;
      c.pkt_size = (g == 3'h2) ? 11'h0003 : 11'h0000;
      c.use_frame = (g >= 3'h3);
      c.frame_start_char_a = 8'h02;
      c.frame_start_char_b = 8'h2b;
      c.start_b_en = (g == 3'h5);
      c.send_start = (g == 3'h4);
      c.frame_end_char_a = 8'h03;
      return c;
   endfunction : base_cfg
   task automatic do_reset();
      ser.idle();
      @(negedge mclk);
      arst_n = 1'b0;
      repeat (20) @(negedge mclk);
      arst_n = 1'b1;
      @(negedge mclk);
   endtask : do_reset
   // The answer to a byte stands for one cycle only, so it is looked at on the very next falling edge.
   task automatic step();
      @(negedge mclk);
   endtask : step
   task automatic chk_tx(input logic [1:0] c, input logic [7:0] e0, input logic [7:0] e1, input logic l);
      checked++;
      if (tx.cnt !== c || tx.last !== l || (c != 2'h0 && tx.b0 !== e0) || (c == 2'h2 && tx.b1 !== e1)) begin
         miscompares++;
         $display("[ERR] tx expected cnt=%0h b0=%h b1=%h last=%b seen cnt=%0h b0=%h b1=%h last=%b",
            c, e0, e1, l, tx.cnt, tx.b0, tx.b1, tx.last);
      end
   endtask : chk_tx
   task automatic chk_bit(input string nm, input logic e, input logic s);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %s expected %b seen %b", nm, e, s);
      end
   endtask : chk_bit
   task automatic chk_range(input string nm, input int lo, input int hi, input int got);
      checked++;
      if (got < lo || got > hi) begin
         miscompares++;
         $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask : chk_range
   // Feeds m bytes, one every per cycles, and counts cycles until a packet closes.
   task automatic timed(input int per, input int m, output int cnt);
      cnt = 0;
      while (cnt < 400 && tx.last !== 1'b1) begin
         if (cnt % per == 0 && cnt / per < m) ser.put(8'h20);
         else ser.idle();
         @(negedge mclk);
         cnt++;
      end
      ser.idle();
   endtask : timed
   task automatic wrap_up();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      arst_n = 1'b0;
      ce = 1'b1;
      cfg = base_cfg(3'h0);
      do_reset();
      chk_bit("pending_after_reset", 1'b0, pending);
      for (int i = 0; i < 27; i++) begin
         if (i == 0 || rows[i].grp != rows[(i == 0) ? 0 : i - 1].grp) begin
            cfg = base_cfg(rows[i].grp);
            do_reset();
         end
         ser.put(rows[i].d);
         step();
         chk_tx(rows[i].cnt, rows[i].b0, rows[i].b1, rows[i].last);
         if (rows[i].pend != 2'h2) chk_bit("pending", rows[i].pend[0], pending);
      end
      $display("test table done");
      for (int r = 0; r < 4; r++) begin
         cfg = base_cfg(3'h1);
         cfg.ready_b_en = 1'b0;
         cfg.rule = framer_pkg::rule_e'(r);
         do_reset();
         ser.put(8'h41);
         step();
         for (int i = 0; i <= ((r >= 2) ? r - 1 : 0); i++) begin
            ser.put(seq[i]);
            step();
            chk_tx((r == 0 && i == 0) ? 2'h0 : 2'h1, seq[i], 8'h00, i == ((r >= 2) ? r - 1 : 0));
         end
      end
      $display("test release rules done");
      cfg = base_cfg(3'h1);
      do_reset();
      ser.put(8'h0d);
      step();
      chk_bit("pending_held", 1'b1, pending);
      ser.idle();
      arst_n = 1'b0;
      @(negedge mclk);
      chk_bit("pending_in_reset", 1'b0, pending);
      chk_tx(2'h0, 8'h00, 8'h00, 1'b0);
      arst_n = 1'b1;
      @(negedge mclk);
      ser.put(8'h0a);
      step();
      chk_tx(2'h1, 8'h0a, 8'h00, 1'b0);
      cfg = base_cfg(3'h0);
      do_reset();
      ce = 1'b0;
      ser.put(8'h5a);
      step();
      chk_tx(2'h0, 8'h00, 8'h00, 1'b0);
      ce = 1'b1;
      ser.put(8'ha5);
      step();
      chk_tx(2'h1, 8'ha5, 8'h00, 1'b1);
      $display("test reset and enable done");
      cfg = base_cfg(3'h0);
      cfg.mode = framer_pkg::MODE_FRAGMENT;
      cfg.msg_delay_ms = 16'h0003;
      do_reset();
      timed(7, 4, n);
      chk_range("fragment_gap", 42, 54, n);
      cfg = base_cfg(3'h2);
      cfg.pkt_size = 11'h0000;
      cfg.idle_ms = 16'h0002;
      do_reset();
      timed(7, 1, n);
      chk_range("idle_close", 12, 22, n);
      cfg.idle_ms = 16'h0002;
      cfg.force_ms = 16'h0004;
      do_reset();
      timed(7, 60, n);
      chk_range("force_close", 31, 42, n);
      cfg = base_cfg(3'h0);
      cfg.mode = framer_pkg::MODE_THROUGHPUT;
      do_reset();
      timed(7, 1, n);
      chk_range("throughput_idle", 41, 52, n);
      $display("test timers done");
      cfg = base_cfg(3'h1);
      cfg.packet_ready_char_a = 8'h3a;
      cfg.packet_ready_char_b = 8'h3b;
      do_reset();
      ser.put(8'h3a);
      step();
      chk_bit("pending_pair", 1'b1, pending);
      ser.put(8'h3b);
      step();
      chk_tx(2'h2, 8'h3a, 8'h3b, 1'b1);
      cfg = base_cfg(3'h3);
      cfg.frame_start_char_a = 8'h5b;
      cfg.frame_end_char_a = 8'h7e;
      cfg.end_b_en = 1'b1;
      cfg.frame_end_char_b = 8'h04;
      do_reset();
      ser.put(8'h5b);
      step();
      ser.put(8'h41);
      step();
      chk_tx(2'h1, 8'h41, 8'h00, 1'b0);
      ser.put(8'h7e);
      step();
      chk_tx(2'h0, 8'h00, 8'h00, 1'b0);
      ser.put(8'h04);
      step();
      chk_tx(2'h2, 8'h7e, 8'h04, 1'b1);
      ser.put(8'h41);
      step();
      chk_tx(2'h0, 8'h00, 8'h00, 1'b0);
      $display("test custom characters done");
      cfg = base_cfg(3'h3);
      do_reset();
      ser.put(8'h02);
      for (int k = 1; k <= 1025; k++) begin
         @(negedge mclk);
         if (k <= 1024) ser.put(8'h40);
         else ser.idle();
         if (k >= 2) chk_bit("frame_full_last", (k - 1) == 1024, tx.last);
      end
      @(negedge mclk);
      ser.put(8'h03);
      step();
      chk_tx(2'h1, 8'h03, 8'h00, 1'b1);
      $display("test frame full done");
      wrap_up();
   end
endmodule : serial_packet_forwarding_framer_tb_top
